/* File: sim/lpm_chk.sv */
`timescale 1ns/1ns
module lpm_chk (
	// Watched ports
	input wire logic       CLK_SYS_I, RESET_N_I, CLK_EN_I, MODE_REQ_I, IRQ_EVENT_I, RADIO_ACTIVE_I, SERIAL_START_I,
	input wire logic       CORE_RUN_O, RADIO_AVAIL_O, RNG_AVAIL_O, PLL_ALLOWED_O, OTHER_PERIPH_RUN_O, SERIAL_WAKE_O,
	input wire logic       EXTERNAL_SLOW_OSC_O, INTERNAL_SLOW_OSC_O, REQ_REFUSED_O, PIN_HOLD_O,
	input wire logic       FIRST_SRAM_PWR_O, SECOND_SRAM_UPPER_PWR_O,
	input wire logic [3:0] MODE_SEL_I,
	input wire logic [8:0] MODE_O
);
	default clocking @(posedge CLK_SYS_I); endclocking
	default disable iff (!RESET_N_I);
	property p_sleep_wake; MODE_O[2] && IRQ_EVENT_I && CLK_EN_I |=> !CORE_RUN_O [*8] ##1 CORE_RUN_O; endproperty
	a_sleep_wake: assert property (p_sleep_wake) else $error("sleep wake latency wrong");
	property p_lp_off; MODE_O[1] || MODE_O[3] |-> !(RADIO_AVAIL_O || RNG_AVAIL_O || PLL_ALLOWED_O); endproperty
	a_lp_off: assert property (p_lp_off) else $error("radio or pll offered in low power");
	property p_stop_frz; MODE_O[4] || MODE_O[5] |-> !OTHER_PERIPH_RUN_O; endproperty
	a_stop_frz: assert property (p_stop_frz) else $error("peripherals not frozen in stop");
	property p_ser_wake; (MODE_O[4] || MODE_O[5]) && $rose(SERIAL_START_I) |-> SERIAL_WAKE_O; endproperty
	a_ser_wake: assert property (p_ser_wake) else $error("serial start gave no wake");
	property p_refuse;
		MODE_REQ_I && CLK_EN_I && MODE_O[0] && MODE_SEL_I == lpm_pkg::REQ_STANDBY && RADIO_ACTIVE_I
			|=> REQ_REFUSED_O && $stable(MODE_O);
	endproperty
	a_refuse: assert property (p_refuse) else $error("standby taken with radio active");
	property p_sby_sram; MODE_O[7] |-> !FIRST_SRAM_PWR_O && !SECOND_SRAM_UPPER_PWR_O; endproperty
	a_sby_sram: assert property (p_sby_sram) else $error("sram left powered in standby");
	property p_shutdn; MODE_O[8] |-> EXTERNAL_SLOW_OSC_O && !INTERNAL_SLOW_OSC_O && !FIRST_SRAM_PWR_O; endproperty
	a_shutdn: assert property (p_shutdn) else $error("shutdown keeps wrong sources");
	property p_pull_drop; $fell(MODE_O[8]) |-> !PIN_HOLD_O; endproperty
	a_pull_drop: assert property (p_pull_drop) else $error("pin hold kept after shutdown");
	cover property (MODE_O[6] && RADIO_ACTIVE_I);
	cover property (REQ_REFUSED_O);
	cover property ($fell(MODE_O[8]));
endmodule : lpm_chk

/* File: sim/lpm_ctrl_tb.sv */
`timescale 1ns/1ns
module lpm_ctrl_tb;
	logic CLK_SYS_I = 0, RESET_N_I = 0, CLK_EN_I = 1, MODE_REQ_I = 0, SRAM_RETAIN_BIT_I = 1, FLASH_PD_REQ_I = 0;
	logic CODE_IN_SRAM_I = 0, FIRST_SRAM_GATE_I = 0, SRAM2_GATE_I = 0, PLL_SEL_I = 0;
	logic RADIO_TXRX_REQ_I = 0, SERIAL_START_I = 0, SERIAL_ADDR_I = 0, SERIAL_FRAME_I = 0, TWO_WIRE_ADDR_I = 0;
	logic RTC_WAKE_I = 0, BASIC_WAKE_I = 0, rad = 0, sb = 0;
	// Pulsed inputs share one vector so a single task can drive any of them
	logic [4:0] pv = 5'h00;
	wire go = pv[0], FLASH_PROG_REQ_I = pv[1], STOP_WAKE_I = pv[2], WAKE_PIN_A_I = pv[3], WAKE_PIN_B_I = pv[4];
	logic [3:0] MODE_SEL_I = 0, dly = 4'h3;
	logic [1:0] FAST_OSC_REQ_I = 0, FAST_OSC_GRANT_O;
	logic [2*lpm_pkg::NUM_PINS-1:0] PIN_PULL_CFG_I = 0, PIN_PULL_O, pull;
	logic [8:0] MODE_O;
	logic IRQ_EVENT_I, RADIO_ACTIVE_I, CORE_RUN_O, MAIN_REGULATOR_O, LOW_POWER_REGULATOR_O, RADIO_AVAIL_O, RNG_AVAIL_O;
	logic PLL_ALLOWED_O, STOP_PERIPH_RUN_O, OTHER_PERIPH_RUN_O, SERIAL_WAKE_O, TWO_WIRE_WAKE_O, INTERNAL_FAST_OSC_O;
	logic EXTERNAL_FAST_OSC_O, EXTERNAL_SLOW_OSC_O, INTERNAL_SLOW_OSC_O, FLASH_ON_O, FLASH_PROG_OK_O, FLASH_PROG_REJ_O;
	logic FIRST_SRAM_PWR_O, RETENTION_SRAM_PWR_O, SECOND_SRAM_UPPER_PWR_O, FIRST_SRAM_CLK_O, SRAM2_CLK_O, PIN_HOLD_O;
	logic REQ_REFUSED_O, RADIO_REINIT_O;
	int n_mismatch = 0, num_checks = 0;
	lpm_ctrl u_lpm_ctrl (.*);
	lpm_far u_lpm_far (.clk_i(CLK_SYS_I), .go_i(go), .dly_i(dly), .radio_req_i(rad), .stdby_req_i(sb),
		.irq_o(IRQ_EVENT_I), .radio_o(RADIO_ACTIVE_I));
	task automatic chk(input logic [63:0] seen, input logic [63:0] exp);
		num_checks++;
		if (seen !== exp) begin
			n_mismatch++;
			$display("CHECK FAILED at %0t: seen %h expected %h", $time, seen, exp);
		end
	endtask : chk
	task automatic req(input logic [3:0] code);
		@(posedge CLK_SYS_I);
		MODE_SEL_I <= code;
		MODE_REQ_I <= 1'b1;
		@(posedge CLK_SYS_I);
		MODE_REQ_I <= 1'b0;
		#1;
	endtask : req
	task automatic pulse(input int k);
		@(posedge CLK_SYS_I);
		pv[k] <= 1'b1;
		@(posedge CLK_SYS_I);
		pv[k] <= 1'b0;
		#1;
	endtask : pulse
	task automatic wrun();
		for (int i = 0; i < 100 && MODE_O !== lpm_pkg::M_RUN; i++)
			@(posedge CLK_SYS_I);
		#1 chk(MODE_O, lpm_pkg::M_RUN);
	endtask : wrun
	task automatic end_sim();
		$display("checks %0d mismatches %0d", num_checks, n_mismatch);
		if (n_mismatch == 0 && num_checks > 0)
			$display("Simulation passed");
		else
			$display("Simulation failed");
		$finish;
	endtask : end_sim
	initial forever #5 CLK_SYS_I = ~CLK_SYS_I;
	initial begin
		repeat (3000) @(posedge CLK_SYS_I);
		n_mismatch++;
		end_sim();
	end
	initial begin
		repeat (16) @(posedge CLK_SYS_I);
		RESET_N_I <= 1'b1;
		#1 chk({MODE_O, CORE_RUN_O, FLASH_ON_O}, {lpm_pkg::M_RUN, 2'b11});
		// Enable low: a request must not move the mode
		CLK_EN_I <= 1'b0;
		req(lpm_pkg::REQ_SLEEP);
		chk(MODE_O, lpm_pkg::M_RUN);
		CLK_EN_I <= 1'b1;
		req(lpm_pkg::REQ_SLEEP);
		FIRST_SRAM_GATE_I <= 1'b1;
		#1 chk({CORE_RUN_O, FIRST_SRAM_CLK_O, SRAM2_CLK_O}, 3'b001);
		{FIRST_SRAM_GATE_I, SRAM2_GATE_I} <= 2'b01;
		#1 chk({FIRST_SRAM_CLK_O, SRAM2_CLK_O}, 2'b10);
		pulse(0);
		wrun();
		$display("test sleep done");
		PLL_SEL_I <= 1'b1;
		req(lpm_pkg::REQ_LPRUN);
		pulse(1);
		chk({RADIO_AVAIL_O, RNG_AVAIL_O, PLL_ALLOWED_O, FLASH_PROG_REJ_O}, 4'b0001);
		req(lpm_pkg::REQ_RUN);
		pulse(1);
		{FLASH_PD_REQ_I, CODE_IN_SRAM_I} <= 2'b11;
		#1 chk({FLASH_PROG_OK_O, FLASH_ON_O}, 2'b10);
		$display("test low power run done");
		{FLASH_PD_REQ_I, CODE_IN_SRAM_I, rad} <= 3'b001;
		req(lpm_pkg::REQ_STANDBY);
		chk({MODE_O, REQ_REFUSED_O}, {lpm_pkg::M_RUN, 1'b1});
		req(lpm_pkg::REQ_STOP2);
		RADIO_TXRX_REQ_I <= 1'b1;
		#1 chk({MODE_O, EXTERNAL_FAST_OSC_O, MAIN_REGULATOR_O}, {lpm_pkg::M_STOP2, 2'b10});
		{RADIO_TXRX_REQ_I, rad} <= 2'b00;
		pulse(2);
		chk({MAIN_REGULATOR_O, CORE_RUN_O}, 2'b10);
		wrun();
		$display("test radio limits done");
		for (int i = 0; i < 2; i++) begin
			req(lpm_pkg::REQ_STOP0 + 4'(i));
			{FAST_OSC_REQ_I, SERIAL_START_I, TWO_WIRE_ADDR_I} <= {2'(i + 1), ~i[0], i[0]};
			#1 chk({OTHER_PERIPH_RUN_O, SERIAL_WAKE_O, TWO_WIRE_WAKE_O}, {1'b0, ~i[0], i[0]});
			chk({INTERNAL_FAST_OSC_O, FAST_OSC_GRANT_O}, {1'b1, 2'(i + 1)});
			{FAST_OSC_REQ_I, SERIAL_START_I, TWO_WIRE_ADDR_I} <= 4'h0;
			#1 chk(INTERNAL_FAST_OSC_O, 1'b0);
			pulse(2);
			wrun();
		end
		$display("test stop modes done");
		sb <= 1'b1;
		for (int i = 0; i < 2; i++) begin
			pull = i ? 32'h2865_a490 : 32'h9a41_5608;
			PIN_PULL_CFG_I <= pull;
			req(lpm_pkg::REQ_STANDBY + 4'(i));
			// Input moves after entry, so only a captured copy can match
			PIN_PULL_CFG_I <= 0;
			repeat (5) @(posedge CLK_SYS_I);
			#1 chk({MODE_O[7 + i], RETENTION_SRAM_PWR_O, PIN_HOLD_O, PIN_PULL_O}, {1'b1, ~i[0], 1'b1, pull});
			pulse(3 + i);
			wrun();
			chk({PIN_HOLD_O, PIN_PULL_O, RADIO_REINIT_O}, {33'h0_0000_0000, ~i[0]});
		end
		$display("test deep modes done");
		end_sim();
	end
endmodule : lpm_ctrl_tb
bind lpm_ctrl lpm_chk u_lpm_chk (.*);

/* File: sim/lpm_far.sv */
`timescale 1ns/1ns
module lpm_far (
	// Bench control
	input  wire logic       clk_i, go_i, radio_req_i, stdby_req_i,
	input  wire logic [3:0] dly_i,
	// Toward the controller
	output wire logic       irq_o, radio_o
);
	logic       fire = 1'b0, rad = 1'b0;
	logic [3:0] cnt  = 4'h0;
	assign irq_o   = fire;
	assign radio_o = rad;
	// Interrupt comes dly_i cycles after go, one cycle wide
	always_ff @(posedge clk_i) begin
		rad  <= radio_req_i & ~stdby_req_i;
		fire <= cnt == 4'h1;
		cnt  <= go_i ? dly_i : cnt - 4'(cnt != 4'h0);
	end
endmodule : lpm_far

/* File: src/lpm_ctrl.sv */
`timescale 1ns/1ns
// Notes on behaviour
// R01: Sleep modes halt the core; any interrupt or event resumes it after 9 cycles.
// R02: Low-power run and sleep keep radio and random generator off, forbid PLL.
// R03: Stop 0/1 keep radio, brownout, detector, RTC, watchdog, serial, two-wire, timers only.
// R04: In stop 0/1, serial receiver wakes on start bit, address match or frame.
// R05: In stop 0/1, two-wire address detector wakes on address match.
// R06: Internal fast oscillator runs on stop-peripheral request, feeds only requesters, auto-off.
// R07: External fast oscillator enabled whenever the radio needs transmit or receive.
// R08: Standby keeps retention SRAM only when the retain bit is set.
// R09: Standby and shutdown also wake from the two dedicated wake pins.
// R10: Shutdown keeps only slow external oscillator and RTC; wakes on pins or RTC.
// R11: Pin pull settings hold for the whole standby period.
// R12: Pin pull settings hold in shutdown and are dropped at once on exit.
// R13: Software stops radio before standby and reinitialises the radio processor after.
// R14: Radio active limits depth to stop 2; no standby or shutdown then.
// R15: Flash programming allowed only in run mode, refused in low-power run.
// R16: Flash power-down allowed only with radio unused and code in SRAM; default off.
// R17: In sleep modes the two SRAM banks' clocks gate independently.
// R18: Stop exit restores the regulator before releasing the core; clocks return with the core.
module lpm_ctrl (
	// Clock, reset, enable
	input  wire logic                   CLK_SYS_I,
	input  wire logic                   RESET_N_I,
	input  wire logic                   CLK_EN_I,
	// Mode request from software
	input  wire logic                   MODE_REQ_I,
	input  wire logic [3:0]             MODE_SEL_I,
	input  wire logic                   SRAM_RETAIN_BIT_I,
	input  wire logic                   FLASH_PD_REQ_I,
	input  wire logic                   CODE_IN_SRAM_I,
	input  wire logic                   FLASH_PROG_REQ_I,
	input  wire logic                   FIRST_SRAM_GATE_I,
	input  wire logic                   SRAM2_GATE_I,
	input  wire logic                   PLL_SEL_I,
	input  wire logic [2*lpm_pkg::NUM_PINS-1:0] PIN_PULL_CFG_I,
	// Wake sources, radio status and fast oscillator requests
	input  wire logic                   IRQ_EVENT_I,
	input  wire logic                   RADIO_ACTIVE_I,
	input  wire logic                   RADIO_TXRX_REQ_I,
	input  wire logic                   STOP_WAKE_I,
	input  wire logic                   SERIAL_START_I,
	input  wire logic                   SERIAL_ADDR_I,
	input  wire logic                   SERIAL_FRAME_I,
	input  wire logic                   TWO_WIRE_ADDR_I,
	input  wire logic                   RTC_WAKE_I,
	input  wire logic                   BASIC_WAKE_I,
	input  wire logic                   WAKE_PIN_A_I,
	input  wire logic                   WAKE_PIN_B_I,
	input  wire logic [1:0]             FAST_OSC_REQ_I,
	// Status and controls
	output logic [8:0]                  MODE_O,
	output logic                        CORE_RUN_O,
	output logic                        MAIN_REGULATOR_O,
	output logic                        LOW_POWER_REGULATOR_O,
	output logic                        RADIO_AVAIL_O,
	output logic                        RNG_AVAIL_O,
	output logic                        PLL_ALLOWED_O,
	output logic                        STOP_PERIPH_RUN_O,
	output logic                        OTHER_PERIPH_RUN_O,
	output logic                        SERIAL_WAKE_O,
	output logic                        TWO_WIRE_WAKE_O,
	output logic                        INTERNAL_FAST_OSC_O,
	output logic [1:0]                  FAST_OSC_GRANT_O,
	output logic                        EXTERNAL_FAST_OSC_O,
	output logic                        EXTERNAL_SLOW_OSC_O,
	output logic                        INTERNAL_SLOW_OSC_O,
	output logic                        FLASH_ON_O,
	output logic                        FLASH_PROG_OK_O,
	output logic                        FLASH_PROG_REJ_O,
	output logic                        FIRST_SRAM_PWR_O,
	output logic                        RETENTION_SRAM_PWR_O,
	output logic                        SECOND_SRAM_UPPER_PWR_O,
	output logic                        FIRST_SRAM_CLK_O,
	output logic                        SRAM2_CLK_O,
	output logic                        PIN_HOLD_O,
	output logic [2*lpm_pkg::NUM_PINS-1:0] PIN_PULL_O,
	output logic                        REQ_REFUSED_O,
	output logic                        RADIO_REINIT_O
);

	typedef struct packed {
		lpm_pkg::lpm_mode_e                 mode;
		lpm_pkg::lpm_mode_e                 back;
		logic [3:0]                         cnt;
		logic                               waking;
		logic                               retain;
		logic                               hold;
		logic [2*lpm_pkg::NUM_PINS-1:0]     pull;
		logic                               refused;
		logic                               prog_ok;
		logic                               prog_rej;
		logic                               reinit;
	} lpm_state_s;

	lpm_state_s st;
	lpm_state_s next_st;

	logic is_sleep;
	logic is_lp;
	logic is_stop01;
	logic is_stop;
	logic wake_stop;
	logic wake_deep;

	assign is_sleep  = st.mode inside {lpm_pkg::M_SLEEP, lpm_pkg::M_LPSLEEP};
	assign is_lp     = st.mode inside {lpm_pkg::M_LPRUN, lpm_pkg::M_LPSLEEP};
	assign is_stop01 = st.mode inside {lpm_pkg::M_STOP0, lpm_pkg::M_STOP1};
	assign is_stop   = is_stop01 || st.mode == lpm_pkg::M_STOP2;
	// Stop 2 has no serial or two-wire wake
	assign wake_stop = STOP_WAKE_I || BASIC_WAKE_I || RTC_WAKE_I ||
		(is_stop01 && (SERIAL_WAKE_O || TWO_WIRE_WAKE_O));
	assign wake_deep = WAKE_PIN_A_I || WAKE_PIN_B_I || RTC_WAKE_I ||  // R09
		(st.mode == lpm_pkg::M_STANDBY && BASIC_WAKE_I);  // R10

	always_comb begin
		next_st          = st;
		next_st.refused  = 1'b0;
		next_st.prog_ok  = FLASH_PROG_REQ_I && st.mode == lpm_pkg::M_RUN && !st.waking;  // R15
		next_st.prog_rej = FLASH_PROG_REQ_I && !next_st.prog_ok;  // R15
		if (st.waking) begin
			if (st.cnt == lpm_pkg::CNT_ZERO) begin
				next_st.waking = 1'b0;
				next_st.mode   = st.back;
			end else begin
				next_st.cnt = st.cnt - 4'h1;
			end
		end else begin
			unique case (st.mode)
				lpm_pkg::M_SLEEP, lpm_pkg::M_LPSLEEP: begin
					if (IRQ_EVENT_I) begin
						next_st.waking = 1'b1;  // R01
						next_st.cnt    = lpm_pkg::WAKE_LAT - 4'h1;
					end
				end
				lpm_pkg::M_STOP0, lpm_pkg::M_STOP1, lpm_pkg::M_STOP2: begin
					if (wake_stop) begin
						next_st.waking = 1'b1;  // R18
						next_st.back   = lpm_pkg::M_RUN;
						next_st.cnt    = lpm_pkg::STOP_RESTORE;
					end
				end
				lpm_pkg::M_STANDBY, lpm_pkg::M_SHUTDN: begin
					if (wake_deep) begin
						next_st.mode   = lpm_pkg::M_RUN;
						next_st.hold   = 1'b0;  // R12
						next_st.reinit = st.mode == lpm_pkg::M_STANDBY;  // R13
					end
				end
				default: begin
					if (MODE_REQ_I) begin
						next_st.back   = st.mode;
						next_st.reinit = 1'b0;
						unique case (MODE_SEL_I)
							lpm_pkg::REQ_RUN:     next_st.mode = lpm_pkg::M_RUN;
							lpm_pkg::REQ_LPRUN:   next_st.mode = lpm_pkg::M_LPRUN;
							lpm_pkg::REQ_SLEEP:   next_st.mode = lpm_pkg::M_SLEEP;
							lpm_pkg::REQ_LPSLEEP: next_st.mode = lpm_pkg::M_LPSLEEP;
							lpm_pkg::REQ_STOP0:   next_st.mode = lpm_pkg::M_STOP0;
							lpm_pkg::REQ_STOP1:   next_st.mode = lpm_pkg::M_STOP1;
							lpm_pkg::REQ_STOP2:   next_st.mode = lpm_pkg::M_STOP2;
							lpm_pkg::REQ_STANDBY, lpm_pkg::REQ_SHUTDN: begin
								if (RADIO_ACTIVE_I) begin
									next_st.refused = 1'b1;  // R14
								end else begin
									next_st.mode   = (MODE_SEL_I == lpm_pkg::REQ_STANDBY) ?
										lpm_pkg::M_STANDBY : lpm_pkg::M_SHUTDN;
									next_st.retain = SRAM_RETAIN_BIT_I;  // R08
									next_st.hold   = 1'b1;  // R11
									next_st.pull   = PIN_PULL_CFG_I;
								end
							end
							default: next_st.refused = 1'b1;
						endcase
						// Sleep returns to run, low-power sleep to low-power run
						if (next_st.mode == lpm_pkg::M_SLEEP) begin
							next_st.back = lpm_pkg::M_RUN;
						end
						if (next_st.mode == lpm_pkg::M_LPSLEEP) begin
							next_st.back = lpm_pkg::M_LPRUN;
						end
					end
				end
			endcase
		end
	end

	always_ff @(posedge CLK_SYS_I or negedge RESET_N_I) begin
		if (!RESET_N_I) begin
			st      <= '0;
			st.mode <= lpm_pkg::M_RUN;
			st.back <= lpm_pkg::M_RUN;
		end else if (CLK_EN_I) begin
			st <= next_st;
		end
	end

	// Mode-derived controls
	assign MODE_O                = st.mode;
	assign CORE_RUN_O            = st.mode inside {lpm_pkg::M_RUN, lpm_pkg::M_LPRUN};  // R18
	assign MAIN_REGULATOR_O      = st.mode inside {lpm_pkg::M_RUN, lpm_pkg::M_SLEEP, lpm_pkg::M_STOP0} || st.waking;
	assign LOW_POWER_REGULATOR_O = !MAIN_REGULATOR_O && st.mode != lpm_pkg::M_SHUTDN;
	assign RADIO_AVAIL_O         = !is_lp && st.mode inside {lpm_pkg::M_RUN, lpm_pkg::M_SLEEP,
		lpm_pkg::M_STOP0, lpm_pkg::M_STOP1, lpm_pkg::M_STOP2};  // R02
	assign RNG_AVAIL_O           = st.mode inside {lpm_pkg::M_RUN, lpm_pkg::M_SLEEP};  // R02
	assign PLL_ALLOWED_O         = PLL_SEL_I && !is_lp && !is_stop && st.mode inside
		{lpm_pkg::M_RUN, lpm_pkg::M_SLEEP};  // R02
	assign STOP_PERIPH_RUN_O     = st.mode != lpm_pkg::M_SHUTDN;  // R03
	assign OTHER_PERIPH_RUN_O    = st.mode inside {lpm_pkg::M_RUN, lpm_pkg::M_LPRUN,
		lpm_pkg::M_SLEEP, lpm_pkg::M_LPSLEEP};  // R03
	assign SERIAL_WAKE_O         = is_stop01 && (SERIAL_START_I || SERIAL_ADDR_I || SERIAL_FRAME_I);  // R04
	assign TWO_WIRE_WAKE_O       = is_stop01 && TWO_WIRE_ADDR_I;  // R05
	assign FAST_OSC_GRANT_O      = is_stop01 ? FAST_OSC_REQ_I : 2'h0;  // R06
	assign INTERNAL_FAST_OSC_O   = |FAST_OSC_GRANT_O || !(is_stop || st.mode inside
		{lpm_pkg::M_STANDBY, lpm_pkg::M_SHUTDN});  // R06
	assign EXTERNAL_FAST_OSC_O   = RADIO_TXRX_REQ_I && RADIO_AVAIL_O;  // R07
	assign EXTERNAL_SLOW_OSC_O   = 1'b1;  // R10
	assign INTERNAL_SLOW_OSC_O   = st.mode != lpm_pkg::M_SHUTDN;  // R10
	assign FLASH_ON_O            = OTHER_PERIPH_RUN_O &&
		!(FLASH_PD_REQ_I && CODE_IN_SRAM_I && !RADIO_ACTIVE_I);  // R16
	assign FLASH_PROG_OK_O       = st.prog_ok;
	assign FLASH_PROG_REJ_O      = st.prog_rej;
	assign FIRST_SRAM_PWR_O      = !(st.mode inside {lpm_pkg::M_STANDBY, lpm_pkg::M_SHUTDN});
	assign SECOND_SRAM_UPPER_PWR_O = FIRST_SRAM_PWR_O;
	assign RETENTION_SRAM_PWR_O  = FIRST_SRAM_PWR_O || (st.mode == lpm_pkg::M_STANDBY && st.retain);  // R08
	assign FIRST_SRAM_CLK_O           = OTHER_PERIPH_RUN_O && !(is_sleep && FIRST_SRAM_GATE_I);  // R17
	assign SRAM2_CLK_O           = OTHER_PERIPH_RUN_O && !(is_sleep && SRAM2_GATE_I);  // R17
	assign PIN_HOLD_O            = st.hold;  // R11
	assign PIN_PULL_O            = st.hold ? st.pull : '0;  // R12
	assign REQ_REFUSED_O         = st.refused;
	assign RADIO_REINIT_O        = st.reinit;

endmodule : lpm_ctrl

/* File: src/lpm_pkg.sv */
package lpm_pkg;

	// Power modes, one-hot
	typedef enum logic [8:0] {
		M_RUN     = 9'h001,
		M_LPRUN   = 9'h002,
		M_SLEEP   = 9'h004,
		M_LPSLEEP = 9'h008,
		M_STOP0   = 9'h010,
		M_STOP1   = 9'h020,
		M_STOP2   = 9'h040,
		M_STANDBY = 9'h080,
		M_SHUTDN  = 9'h100
	} lpm_mode_e;

	// Requested mode codes on the request port
	localparam logic [3:0] REQ_RUN     = 4'h0;
	localparam logic [3:0] REQ_LPRUN   = 4'h1;
	localparam logic [3:0] REQ_SLEEP   = 4'h2;
	localparam logic [3:0] REQ_LPSLEEP = 4'h3;
	localparam logic [3:0] REQ_STOP0   = 4'h4;
	localparam logic [3:0] REQ_STOP1   = 4'h5;
	localparam logic [3:0] REQ_STOP2   = 4'h6;
	localparam logic [3:0] REQ_STANDBY = 4'h7;
	localparam logic [3:0] REQ_SHUTDN  = 4'h8;

	// Pin hold encodings
	localparam logic [1:0] PULL_FLOAT = 2'h0;
	localparam logic [1:0] PULL_UP    = 2'h1;
	localparam logic [1:0] PULL_DOWN  = 2'h2;

	localparam int          NUM_PINS        = 16;
	localparam int          WAKE_LAT_CYC    = 9;
	localparam logic [3:0]  WAKE_LAT        = 4'(WAKE_LAT_CYC - 1);
	// Stop exit: regulator settles one cycle longer than this count before core release
	localparam logic [3:0]  STOP_RESTORE    = 4'h4;
	localparam logic [3:0]  CNT_ZERO        = 4'h0;

endpackage : lpm_pkg
